// *** cfg_host.sv ***
`timescale 1ns/1ps

// Requester model: tile or debugger issuing configuration reads and writes
module cfg_host (
  // Clock
  input  wire logic                clk,
  // Request side
  output logic                     valid,
  output node_cfg_pkg::cfg_req_type req
);
  // Quiet bus at time zero
  initial
  begin
    valid = 1'h0;
    req = '0;
  end

  // Request held through the edge that takes it, one word each
  task automatic issue(input logic w, input logic [7:0] n, input logic [31:0] d);
    valid = 1'h1;
    req = '{write: w, num: n, wdata: d};
    @(posedge clk);
    #1;
  endtask

  // Released fields change, so a stale request never looks valid
  task automatic idle();
    valid = 1'h0;
    req = ~req;
  endtask
endmodule

// *** node_cfg_pkg.sv ***
package node_cfg_pkg;

  // Register numbers of the node register set
  localparam logic [7:0] REG_DEVICE_IDENT    = 8'h00;
  localparam logic [7:0] REG_SWITCH_DESC     = 8'h01;
  localparam logic [7:0] REG_SWITCH_CONFIG   = 8'h04;
  localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
  localparam logic [7:0] REG_PLL_SETTINGS    = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLK_DIV  = 8'h07;
  localparam logic [7:0] REG_REF_CLK_DIV     = 8'h08;
  localparam logic [7:0] REG_JTAG_IDENT      = 8'h09;
  localparam logic [7:0] REG_USER_CODE       = 8'h0a;
  localparam logic [7:0] REG_ROUTE_DIRS_LOW  = 8'h0c;
  localparam logic [7:0] REG_ROUTE_DIRS_HIGH = 8'h0d;
  localparam logic [7:0] REG_DEBUG_PIN_CFG0  = 8'h10;
  localparam logic [7:0] REG_DEBUG_PIN_CFG1  = 8'h11;
  localparam logic [7:0] REG_DEBUG_SOURCE    = 8'h1f;
  localparam logic [7:0] REG_LINK_STATUS_LO  = 8'h20;
  localparam logic [7:0] REG_LINK_STATUS_HI  = 8'h28;
  localparam logic [7:0] REG_PROC_LINK_LO    = 8'h40;
  localparam logic [7:0] REG_PROC_LINK_HI    = 8'h47;
  localparam logic [7:0] REG_LINK_CFG_LO     = 8'h80;
  localparam logic [7:0] REG_LINK_CFG_HI     = 8'h88;
  localparam logic [7:0] REG_STATIC_LINK_LO  = 8'ha0;
  localparam logic [7:0] REG_STATIC_LINK_HI  = 8'ha7;

  // Field positions
  localparam int BYTE2_LSB         = 16;
  localparam int BYTE1_LSB         = 8;
  localparam int CFG_LOCK_ALL_BIT  = 31;
  localparam int CFG_LOCK_PLL_BIT  = 8;
  localparam int CFG_HDR_MODE_BIT  = 0;
  localparam int PLL_NO_RESET_BIT  = 31;
  localparam int PLL_NO_RELOCK_BIT = 30;
  localparam int PLL_BYPASS_BIT    = 29;
  localparam int PLL_JTAG_BOOT_BIT = 28;
  localparam int PLL_OUT_DIV_LSB   = 23;
  localparam int PLL_MULT_LSB      = 8;
  localparam int PLL_IN_DIV_LSB    = 0;
  localparam int USER_OTP_LSB      = 18;

  // Field widths
  localparam int ID_WIDTH      = 16;
  localparam int DIR_WIDTH     = 4;
  localparam int OUT_DIV_WIDTH = 3;
  localparam int MULT_WIDTH    = 13;
  localparam int IN_DIV_WIDTH  = 7;
  localparam int OTP_WIDTH     = 14;
  localparam int METAL_WIDTH   = 18;

  // Reset values
  localparam logic [15:0] NODE_ID_RESET    = 16'h0000;
  localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
  localparam logic [15:0] REF_DIV_RESET    = 16'h0003;
  localparam logic [31:0] DIRS_RESET       = 32'h0000_0000;

  // Largest documented field codes
  localparam logic [7:0] OUT_DIV_MAX_CODE = 8'hf9;
  localparam logic [7:0] MULT_MAX_CODE    = 8'hfe;
  localparam logic [7:0] IN_DIV_MAX_CODE  = 8'h0f;

  typedef struct packed {
    logic        write;
    logic [7:0]  num;
    logic [31:0] wdata;
  } cfg_req_type;

  typedef struct packed {
    logic        err;
    logic [31:0] rdata;
  } cfg_rsp_type;

  typedef struct packed {
    logic [OUT_DIV_WIDTH-1:0] out_div;
    logic [MULT_WIDTH-1:0]    mult;
    logic [IN_DIV_WIDTH-1:0]  in_div;
  } pll_fields_type;

endpackage

// *** route_lookup.sv ***
`timescale 1ns/1ps

// Picks the direction of the most significant mismatching identifier bit
module route_lookup #(
  parameter int ID_WIDTH  = 16,
  parameter int DIR_WIDTH = 4
) (
  // Identifiers
  input  wire logic [ID_WIDTH-1:0]           node_id,
  input  wire logic [ID_WIDTH-1:0]           dest_id,
  // Direction table, dimension 0 in the low bits
  input  wire logic [ID_WIDTH*DIR_WIDTH-1:0] dir_table,
  // Result
  output logic      [DIR_WIDTH-1:0]          dir,
  output logic                               local_hit
);

  logic [ID_WIDTH-1:0] diff;

  assign diff = node_id ^ dest_id;

  // Ascending scan, so the highest mismatching bit is the last to win
  always_comb
  begin
    dir = '0;
    for (int i = 0; i < ID_WIDTH; i++)
    begin
      if (diff[i])
      begin
        dir = dir_table[i*DIR_WIDTH +: DIR_WIDTH];
      end
    end
    local_hit = (diff == '0);
  end

endmodule

// *** switch_node_config_regs.sv ***
`timescale 1ns/1ps

// Contract
// - Registers are reached only by configuration reads and writes by register number.
// - Identification bits 23:16 show boot control pins captured after reset, then frozen.
// - Identification bits 15:8 revision, 7:0 version, read-only; 31:24 reserved.
// - Description shows serial link count, switch processors, device processors, read-only.
// - Config bit 31 set blocks writes to all switch control registers; resets 0.
// - Config bit 8 set blocks writes to the PLL register; resets 0.
// - Config bit 0 selects one-byte headers when 1, two-byte when 0.
// - Node identifier holds writable 16-bit identity, resets zero, upper bits reserved.
// - Any PLL register write resets the tile unless suppressed.
// - PLL write with bit 31 set performs no chip reset.
// - PLL bit 30 set skips waiting for PLL re-lock.
// - PLL bit 29 written 1 bypasses the PLL.
// - PLL bit 28 written 1 selects boot from the JTAG port.
// - PLL bits 25:23 hold output divider minus one.
// - PLL bits 20:8 hold feedback multiplier minus one.
// - PLL bits 6:0 hold input divider minus one.
// - Switch clock divider bits 15:0 writable, resets zero.
// - Reference clock divider bits 15:0 writable, resets to three.
// - User code register returns OTP user code 31:18 and metal code 17:0.
// - Low directions register holds dimensions 0 to 7, four bits each, resets zero.
// - Packets route by the direction of the most significant mismatching identifier bit.
// - High directions register holds dimensions 8 to 15, four bits each, resets zero.
module switch_node_config_regs #(
  parameter logic [7:0]  SWITCH_REVISION   = 8'h01, // Arbitrary value
  parameter logic [7:0]  SWITCH_VERSION    = 8'h01, // Arbitrary value
  parameter logic [7:0]  NUM_SERIAL_LINKS  = 8'h08,
  parameter logic [7:0]  NUM_SWITCH_PROCS  = 8'h02,
  parameter logic [7:0]  NUM_DEVICE_PROCS  = 8'h02,
  parameter logic [31:0] JTAG_IDENT_VALUE  = 32'h0000_0001, // Arbitrary value
  parameter int          BOOT_PINS_WIDTH   = 8
) (
  // Clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  // Configuration requests
  input  wire logic                                  cfg_req_valid,
  input  wire node_cfg_pkg::cfg_req_type             cfg_req,
  output node_cfg_pkg::cfg_rsp_type                  cfg_rsp,
  output logic                                       cfg_rsp_valid,
  // Straps and one-time values
  input  wire logic [BOOT_PINS_WIDTH-1:0]            boot_control_pins,
  input  wire logic [node_cfg_pkg::OTP_WIDTH-1:0]    otp_user_code,
  input  wire logic [node_cfg_pkg::METAL_WIDTH-1:0]  metal_id_code,
  // Routing lookups
  input  wire logic                                  route_valid,
  input  wire logic [node_cfg_pkg::ID_WIDTH-1:0]     route_dest,
  output logic                                       route_done,
  output logic [node_cfg_pkg::DIR_WIDTH-1:0]         route_dir,
  output logic                                       route_local,
  // Switch settings
  output logic                                       header_one_byte,
  output logic [node_cfg_pkg::ID_WIDTH-1:0]          node_id,
  output logic [15:0]                                switch_clk_div,
  output logic [15:0]                                ref_clk_div,
  // PLL control
  output node_cfg_pkg::pll_fields_type               pll_fields,
  output logic                                       pll_skip_relock,
  output logic                                       pll_bypass,
  output logic                                       boot_from_jtag,
  output logic                                       tile_reset_pulse
);

  logic                                    lock_all_q;
  logic                                    lock_pll_q;
  logic                                    hdr_one_byte_q;
  logic [node_cfg_pkg::ID_WIDTH-1:0]       node_id_q;
  logic [15:0]                             switch_div_q;
  logic [15:0]                             ref_div_q;
  node_cfg_pkg::pll_fields_type            pll_q;
  logic                                    pll_no_reset_q;
  logic                                    pll_no_relock_q;
  logic                                    pll_bypass_q;
  logic                                    jtag_boot_q;
  logic                                    tile_reset_q;
  logic [31:0]                             dirs_low_q;
  logic [31:0]                             dirs_high_q;
  logic [BOOT_PINS_WIDTH-1:0]              boot_s1_q;
  logic [BOOT_PINS_WIDTH-1:0]              boot_s2_q;
  logic [BOOT_PINS_WIDTH-1:0]              boot_s3_q;
  logic [BOOT_PINS_WIDTH-1:0]              boot_pins_q;
  logic                                    boot_pending_q;
  node_cfg_pkg::cfg_rsp_type               rsp_q;
  node_cfg_pkg::cfg_rsp_type               rsp_d;
  logic                                    rsp_valid_q;
  logic                                    route_done_q;
  logic [node_cfg_pkg::DIR_WIDTH-1:0]      route_dir_q;
  logic                                    route_local_q;
  logic [node_cfg_pkg::DIR_WIDTH-1:0]      lookup_dir;
  logic                                    lookup_local;
  logic                                    wr_any;
  logic                                    wr_ok;
  logic                                    pll_wr_ok;
  logic [31:0]                             wd;

  // Write qualification: the lock bit covers every writable register
  assign wr_any    = cfg_req_valid && cfg_req.write;
  assign wr_ok     = wr_any && !lock_all_q;
  assign pll_wr_ok = wr_ok && (cfg_req.num == node_cfg_pkg::REG_PLL_SETTINGS) && !lock_pll_q;
  assign wd        = cfg_req.wdata;

  // Strap synchroniser kept out of reset, so it holds real pin levels, not zeros, when reset lifts
  always_ff @(posedge clk)
  begin
    boot_s1_q <= boot_control_pins;
    boot_s2_q <= boot_s1_q;
    boot_s3_q <= boot_s2_q;
  end

  // Strap capture after reset release, then frozen until next reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      boot_pins_q    <= '0;
      boot_pending_q <= 1'b1;
    end
    else if (boot_pending_q && (boot_s2_q == boot_s3_q))
    begin
      boot_pins_q    <= boot_s3_q;
      boot_pending_q <= 1'b0;
    end
  end

  // Switch configuration; locking itself too, so only reset undoes it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lock_all_q     <= 1'b0;
      lock_pll_q     <= 1'b0;
      hdr_one_byte_q <= 1'b0;
    end
    else if (wr_ok && (cfg_req.num == node_cfg_pkg::REG_SWITCH_CONFIG))
    begin
      lock_all_q     <= wd[node_cfg_pkg::CFG_LOCK_ALL_BIT];
      lock_pll_q     <= wd[node_cfg_pkg::CFG_LOCK_PLL_BIT];
      hdr_one_byte_q <= wd[node_cfg_pkg::CFG_HDR_MODE_BIT];
    end
  end

  // Node identity and clock dividers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      node_id_q    <= node_cfg_pkg::NODE_ID_RESET;
      switch_div_q <= node_cfg_pkg::SWITCH_DIV_RESET;
      ref_div_q    <= node_cfg_pkg::REF_DIV_RESET;
    end
    else if (wr_ok)
    begin
      case (cfg_req.num)
        node_cfg_pkg::REG_NODE_IDENTIFIER: node_id_q    <= wd[15:0];
        node_cfg_pkg::REG_SWITCH_CLK_DIV:  switch_div_q <= wd[15:0];
        node_cfg_pkg::REG_REF_CLK_DIV:     ref_div_q    <= wd[15:0];
        default: ;
      endcase
    end
  end

  // Routing tables
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dirs_low_q  <= node_cfg_pkg::DIRS_RESET;
      dirs_high_q <= node_cfg_pkg::DIRS_RESET;
    end
    else if (wr_ok)
    begin
      case (cfg_req.num)
        node_cfg_pkg::REG_ROUTE_DIRS_LOW:  dirs_low_q  <= wd;
        node_cfg_pkg::REG_ROUTE_DIRS_HIGH: dirs_high_q <= wd;
        default: ;
      endcase
    end
  end

  // PLL settings; the value only matters once the tile reset acts
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pll_q           <= '0;
      pll_no_reset_q  <= 1'b0;
      pll_no_relock_q <= 1'b0;
      pll_bypass_q    <= 1'b0;
      jtag_boot_q     <= 1'b0;
    end
    else if (pll_wr_ok)
    begin
      pll_q.out_div   <= wd[node_cfg_pkg::PLL_OUT_DIV_LSB +: node_cfg_pkg::OUT_DIV_WIDTH];
      pll_q.mult      <= wd[node_cfg_pkg::PLL_MULT_LSB +: node_cfg_pkg::MULT_WIDTH];
      pll_q.in_div    <= wd[node_cfg_pkg::PLL_IN_DIV_LSB +: node_cfg_pkg::IN_DIV_WIDTH];
      pll_no_reset_q  <= wd[node_cfg_pkg::PLL_NO_RESET_BIT];
      pll_no_relock_q <= wd[node_cfg_pkg::PLL_NO_RELOCK_BIT];
      pll_bypass_q    <= wd[node_cfg_pkg::PLL_BYPASS_BIT];
      jtag_boot_q     <= wd[node_cfg_pkg::PLL_JTAG_BOOT_BIT];
    end
  end

  // Tile reset request: one pulse per accepted PLL write with bit 31 clear; reset folded into the term
  always_ff @(posedge clk)
  begin
    tile_reset_q <= reset_n && pll_wr_ok && !wd[node_cfg_pkg::PLL_NO_RESET_BIT];
  end

  // Read data; reserved and unbuilt fields read zero
  always_comb
  begin
    rsp_d = '0;
    case (cfg_req.num)
      node_cfg_pkg::REG_DEVICE_IDENT:
      begin
        rsp_d.rdata[node_cfg_pkg::BYTE2_LSB +: BOOT_PINS_WIDTH] = boot_pins_q;
        rsp_d.rdata[15:8] = SWITCH_REVISION;
        rsp_d.rdata[7:0]  = SWITCH_VERSION;
      end
      node_cfg_pkg::REG_SWITCH_DESC:
      begin
        rsp_d.rdata = {8'h00, NUM_SERIAL_LINKS, NUM_SWITCH_PROCS, NUM_DEVICE_PROCS};
      end
      node_cfg_pkg::REG_SWITCH_CONFIG:
      begin
        rsp_d.rdata[node_cfg_pkg::CFG_LOCK_ALL_BIT] = lock_all_q;
        rsp_d.rdata[node_cfg_pkg::CFG_LOCK_PLL_BIT] = lock_pll_q;
        rsp_d.rdata[node_cfg_pkg::CFG_HDR_MODE_BIT] = hdr_one_byte_q;
      end
      node_cfg_pkg::REG_NODE_IDENTIFIER: rsp_d.rdata[15:0] = node_id_q;
      node_cfg_pkg::REG_PLL_SETTINGS:
      begin
        // Bypass and JTAG boot are write-only and read zero
        rsp_d.rdata[node_cfg_pkg::PLL_NO_RESET_BIT]  = pll_no_reset_q;
        rsp_d.rdata[node_cfg_pkg::PLL_NO_RELOCK_BIT] = pll_no_relock_q;
        rsp_d.rdata[node_cfg_pkg::PLL_OUT_DIV_LSB +: node_cfg_pkg::OUT_DIV_WIDTH] = pll_q.out_div;
        rsp_d.rdata[node_cfg_pkg::PLL_MULT_LSB +: node_cfg_pkg::MULT_WIDTH]       = pll_q.mult;
        rsp_d.rdata[node_cfg_pkg::PLL_IN_DIV_LSB +: node_cfg_pkg::IN_DIV_WIDTH]   = pll_q.in_div;
      end
      node_cfg_pkg::REG_SWITCH_CLK_DIV:  rsp_d.rdata[15:0] = switch_div_q;
      node_cfg_pkg::REG_REF_CLK_DIV:     rsp_d.rdata[15:0] = ref_div_q;
      node_cfg_pkg::REG_JTAG_IDENT:      rsp_d.rdata = JTAG_IDENT_VALUE;
      node_cfg_pkg::REG_USER_CODE:       rsp_d.rdata = {otp_user_code, metal_id_code};
      node_cfg_pkg::REG_ROUTE_DIRS_LOW:  rsp_d.rdata = dirs_low_q;
      node_cfg_pkg::REG_ROUTE_DIRS_HIGH: rsp_d.rdata = dirs_high_q;
      node_cfg_pkg::REG_DEBUG_PIN_CFG0,
      node_cfg_pkg::REG_DEBUG_PIN_CFG1,
      node_cfg_pkg::REG_DEBUG_SOURCE:    rsp_d.rdata = '0;
      default:
      begin
        // Link ranges live elsewhere; anything else is unmapped
        rsp_d.err = !((cfg_req.num >= node_cfg_pkg::REG_LINK_STATUS_LO && cfg_req.num <= node_cfg_pkg::REG_LINK_STATUS_HI)
                   || (cfg_req.num >= node_cfg_pkg::REG_PROC_LINK_LO && cfg_req.num <= node_cfg_pkg::REG_PROC_LINK_HI)
                   || (cfg_req.num >= node_cfg_pkg::REG_LINK_CFG_LO && cfg_req.num <= node_cfg_pkg::REG_LINK_CFG_HI)
                   || (cfg_req.num >= node_cfg_pkg::REG_STATIC_LINK_LO
                       && cfg_req.num <= node_cfg_pkg::REG_STATIC_LINK_HI));
      end
    endcase
    rsp_d.rdata = cfg_req.write ? 32'h0000_0000 : rsp_d.rdata; // Write answers carry no data
  end

  // Answer one cycle after every request
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rsp_q       <= '0;
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= cfg_req_valid;
      if (cfg_req_valid)
      begin
        rsp_q <= rsp_d;
      end
    end
  end

  route_lookup #(
    .ID_WIDTH  (node_cfg_pkg::ID_WIDTH),
    .DIR_WIDTH (node_cfg_pkg::DIR_WIDTH)
  ) u_route_lookup (
    .node_id   (node_id_q),
    .dest_id   (route_dest),
    .dir_table ({dirs_high_q, dirs_low_q}),
    .dir       (lookup_dir),
    .local_hit (lookup_local)
  );

  // Registered routing answer; local packets carry no direction
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      route_done_q  <= 1'b0;
      route_dir_q   <= '0;
      route_local_q <= 1'b0;
    end
    else
    begin
      route_done_q <= route_valid;
      if (route_valid)
      begin
        route_local_q <= lookup_local;
        route_dir_q   <= lookup_local ? '0 : lookup_dir;
      end
    end
  end

  // Outputs straight from flip-flops
  assign cfg_rsp          = rsp_q;
  assign cfg_rsp_valid    = rsp_valid_q;
  assign route_done       = route_done_q;
  assign route_dir        = route_dir_q;
  assign route_local      = route_local_q;
  assign header_one_byte  = hdr_one_byte_q;
  assign node_id          = node_id_q;
  assign switch_clk_div   = switch_div_q;
  assign ref_clk_div      = ref_div_q;
  assign pll_fields       = pll_q;
  assign pll_skip_relock  = pll_no_relock_q;
  assign pll_bypass       = pll_bypass_q;
  assign boot_from_jtag   = jtag_boot_q;
  assign tile_reset_pulse = tile_reset_q;

  // Checks
  sequence pll_write_s;
    cfg_req_valid && cfg_req.write && (cfg_req.num == node_cfg_pkg::REG_PLL_SETTINGS)
      && !lock_all_q && !lock_pll_q;
  endsequence
  sequence reset_pulse_s;
    tile_reset_q ##1 !tile_reset_q;
  endsequence
  answer_timing_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_req_valid |=> cfg_rsp_valid)
    else $error("request not answered in one cycle");
  node_id_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_ok && cfg_req.num == node_cfg_pkg::REG_NODE_IDENTIFIER) |=> (node_id == $past(cfg_req.wdata[15:0])))
    else $error("node identifier not written");
  lock_all_blocks_a: assert property (@(posedge clk) disable iff (!reset_n)
    (lock_all_q && wr_any) |=> ($stable(node_id) && $stable(dirs_low_q) && $stable(ref_clk_div)))
    else $error("write went through while locked");
  pll_lock_blocks_a: assert property (@(posedge clk) disable iff (!reset_n)
    (lock_pll_q && wr_any && cfg_req.num == node_cfg_pkg::REG_PLL_SETTINGS) |=> (!tile_reset_q && $stable(pll_q)))
    else $error("PLL register written while protected");
  tile_reset_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pll_write_s and !cfg_req.wdata[node_cfg_pkg::PLL_NO_RESET_BIT]) |=> reset_pulse_s or (tile_reset_q ##1 tile_reset_q))
    else $error("PLL write gave no tile reset");
  reset_suppress_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pll_write_s and cfg_req.wdata[node_cfg_pkg::PLL_NO_RESET_BIT]) |=> !tile_reset_pulse)
    else $error("tile reset despite suppress bit");
  ref_div_reset_a: assert property (@(posedge clk)
    !reset_n |=> (ref_clk_div == node_cfg_pkg::REF_DIV_RESET && switch_clk_div == node_cfg_pkg::SWITCH_DIV_RESET))
    else $error("divider reset value wrong");
  boot_frozen_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!boot_pending_q && !$past(boot_pending_q)) |-> $stable(boot_pins_q))
    else $error("boot pins changed after capture");
  local_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    (route_valid && route_dest == node_id_q) |=> (route_done && route_local && route_dir == '0))
    else $error("own identifier not delivered locally");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg_req_valid && !cfg_req.write && cfg_req.num == node_cfg_pkg::REG_NODE_IDENTIFIER)
      |=> (cfg_rsp.rdata[31:16] == 16'h0000 && !cfg_rsp.err))
    else $error("reserved bits not zero");

endmodule

// *** tb_switch_node_config_regs.sv ***
`timescale 1ns/1ps

module tb_switch_node_config_regs;
  logic                         clk = 1'h0;
  logic                         reset_n = 1'h0;
  logic                         cfg_req_valid, cfg_rsp_valid, route_valid = 1'h0, route_done, route_local;
  logic                         header_one_byte, pll_skip_relock, pll_bypass, boot_from_jtag, tile_reset_pulse;
  node_cfg_pkg::cfg_req_type    cfg_req;
  node_cfg_pkg::cfg_rsp_type    cfg_rsp;
  node_cfg_pkg::pll_fields_type pll_fields;
  logic [7:0]                   boot_control_pins;
  logic [13:0]                  otp_user_code;
  logic [17:0]                  metal_id_code;
  logic [15:0]                  route_dest = 16'h0;
  logic [15:0]                  node_id, switch_clk_div, ref_clk_div, me;
  logic [3:0]                   route_dir;
  logic [31:0]                  seed = 32'h3;
  logic [31:0]                  v, v2;
  logic [63:0]                  dirs;
  logic [33:0]                  rsp_q[$];
  logic [4:0]                   route_q[$];
  int                           n_mismatch = 0;
  int                           samples_checked = 0;
  localparam logic [7:0]  NUMS [5] = '{8'h05, 8'h07, 8'h08, 8'h0c, 8'h0d};
  localparam logic [31:0] MASK [5] = '{32'hffff, 32'hffff, 32'hffff, 32'hffff_ffff, 32'hffff_ffff};
  localparam logic [31:0] RSTV [5] = '{32'h0, 32'h0, 32'h3, 32'h0, 32'h0};
  // Read-only and unbuilt numbers: writes must leave no trace
  localparam logic [7:0]  RO_NUMS [5] = '{8'h00, 8'h01, 8'h09, 8'h0a, 8'h1f};

  cfg_host u_host (.clk, .valid(cfg_req_valid), .req(cfg_req));
  switch_node_config_regs u_dut (.clk, .reset_n, .cfg_req_valid, .cfg_req, .cfg_rsp, .cfg_rsp_valid,
    .boot_control_pins, .otp_user_code, .metal_id_code, .route_valid, .route_dest, .route_done,
    .route_dir, .route_local, .header_one_byte, .node_id, .switch_clk_div, .ref_clk_div, .pll_fields,
    .pll_skip_relock, .pll_bypass, .boot_from_jtag, .tile_reset_pulse);

  // Free-running clock
  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Highest mismatching bit picks the field; full match goes local
  function automatic logic [4:0] route_exp(input logic [15:0] d);
    logic [4:0] r;
    r = 5'h10;
    for (int k = 0; k < 16; k++)
      if (d[k] ^ me[k])
        r = {1'h0, dirs[4*k+:4]};
    return r;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Note: reset pulse flag, error flag, data
  task automatic wr(input logic [7:0] n, input logic [31:0] d, input logic p = 1'h0);
    rsp_q.push_back({p, 1'h0, 32'h0});
    u_host.issue(1'h1, n, d);
  endtask

  task automatic rd(input logic [7:0] n, input logic [31:0] e, input logic er = 1'h0);
    rsp_q.push_back({1'h0, er, e});
    u_host.issue(1'h0, n, rnd());
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Monitor: settled outputs are compared mid-cycle against the oldest note
  always @(negedge clk)
  begin
    if (cfg_rsp_valid === 1'h1)
      check({tile_reset_pulse, cfg_rsp}, rsp_q.pop_front());
    if (route_done === 1'h1)
      check({route_local, route_dir}, route_q.pop_front());
  end

  // Hang guard sized well past the sequence length
  initial
  begin
    #40000;
    n_mismatch++;
    test_done();
  end

  initial
  begin
    v = rnd();
    {otp_user_code, metal_id_code} = v;
    v = rnd();
    boot_control_pins = v[7:0];
    repeat (6) tick();
    reset_n = 1'h1;
    rd(8'h04, 32'h0);
    rd(8'h06, 32'h0);
    for (int i = 0; i < 5; i++)
      rd(NUMS[i], RSTV[i]);
    for (int i = 0; i < 5; i++)
      wr(RO_NUMS[i], 32'hffff_ffff);
    rd(8'h00, {8'h00, boot_control_pins, 8'h01, 8'h01});
    rd(8'h01, 32'h0008_0202);
    rd(8'h09, 32'h1);
    rd(8'h0a, {otp_user_code, metal_id_code});
    rd(8'h02, 32'h0, 1'h1);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      v = rnd();
      wr(NUMS[i], v);
      rd(NUMS[i], v & MASK[i]);
    end
    v = rnd() & 32'h7fff_ffff;
    wr(8'h06, v, 1'h1);
    u_host.idle();
    tick();
    check({pll_skip_relock, pll_bypass, boot_from_jtag, pll_fields}, {v[30:28], v[25:23], v[20:8], v[6:0]});
    rd(8'h06, v & 32'hc39f_ff7f);
    v2 = rnd() & 32'h7fff_ffff;
    wr(8'h06, v | 32'h8000_0000);
    wr(8'h06, v2, 1'h1);
    wr(8'h04, 32'h0000_0101);
    u_host.idle();
    tick();
    check(header_one_byte, 1'h1);
    wr(8'h06, rnd() & 32'h7fff_ffff);
    rd(8'h06, v2 & 32'hc39f_ff7f);
    v = rnd();
    me = v[15:0];
    wr(8'h05, v);
    v = rnd();
    dirs[31:0] = v;
    wr(8'h0c, v);
    v = rnd();
    dirs[63:32] = v;
    wr(8'h0d, v);
    u_host.idle();
    tick();
    for (int i = 0; i < 24; i++)
    begin
      v = rnd();
      route_dest = (i == 0) ? me : me ^ (v[15:0] >> v[19:16]);
      route_valid = 1'h1;
      route_q.push_back(route_exp(route_dest));
      tick();
    end
    route_valid = 1'h0;
    wr(8'h04, 32'h8000_0000);
    wr(8'h05, {16'h0, ~me});
    wr(8'h04, 32'h0);
    rd(8'h05, {16'h0, me});
    rd(8'h04, 32'h8000_0000);
    u_host.idle();
    repeat (3) tick();
    check(node_id, me);
    reset_n = 1'h0;
    repeat (6) tick();
    reset_n = 1'h1;
    check({ref_clk_div, switch_clk_div}, 32'h0003_0000);
    rd(8'h04, 32'h0);
    rd(8'h05, 32'h0);
    u_host.idle();
    repeat (4) tick();
    // Every noted request must have been answered by now
    check(rsp_q.size() + route_q.size(), 0);
    test_done();
  end
endmodule
